// [pkg/rac_defines.svh]
// Purpose: Offsets, field positions, reset values and timing for the
//          receive auxiliary control register slice.
// Assumes: Avalon-MM byte addressing, one 32-bit word per register.
// Notes:   Register index times four gives the byte address.
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH

// Register indices
`define RAC_IDX_AFC_LIMIT   12'h315
`define RAC_IDX_IR_CAL      12'h319
`define RAC_IDX_SHUTDOWN    12'h322
`define RAC_IDX_RX_POWER    12'h324

// Bus geometry
`define RAC_ADDR_W          14
`define RAC_DATA_W          32

// Reset values
`define RAC_RST_AFC_LIMIT   8'h32
`define RAC_RST_IR_CAL      6'h00
`define RAC_RST_SHUTDOWN    1'h0
`define RAC_RST_RX_POWER    5'h00

// Image-reject setup fields
`define RAC_IR_OVR_BIT      5
`define RAC_IR_FREQ_HI      4
`define RAC_IR_FREQ_LO      3
`define RAC_IR_LVL_HI       2
`define RAC_IR_LVL_LO       0

// Shutdown field
`define RAC_SHDN_BIT        0

// Receive enable fields
`define RAC_RX_CONV_BIT     4
`define RAC_RX_SIGSTR_BIT   3
`define RAC_RX_IFFILT_BIT   2
`define RAC_RX_MIXER_BIT    1
`define RAC_RX_LNA_BIT      0

// Timing
`define RAC_CLK_HZ          10000000
`define RAC_SYNC_STAGES     2

`endif

// [pkg/rac_pkg.sv]
// Purpose: Types shared by the receive auxiliary control slice.
// Assumes: Constants come from rac_defines.svh.
// Notes:   Holds enumerations only.
package rac_pkg;

    // Bus handshake state
    typedef enum logic [1:0] {
        RAC_IDLE = 2'b00,
        RAC_ACK  = 2'b01
    } rac_bus_state_t;

    // Test tone crystal divider choice
    typedef enum logic [2:0] {
        RAC_DIV_OFF = 3'b000,
        RAC_DIV_4   = 3'b001,
        RAC_DIV_8   = 3'b010,
        RAC_DIV_16  = 3'b011
    } rac_tone_div_t;

endpackage

// [rtl/rac_sync.sv]
// Purpose: Two-flop synchroniser for an asynchronous pin.
// Assumes: Pin is a slow level.
// Notes:   First stage feeds only the second.
module rac_sync
    import rac_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Pin and result
    input  wire logic pin_in,
    output logic      level_out
);

    logic meta_q;
    logic sync_q;

    // Two flip-flop stage
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign level_out = sync_q;

endmodule

// [rtl/rac_tone_decode.sv]
// Purpose: Decode image-reject test tone fields.
// Assumes: Pure combinational; caller registers results.
// Notes:   Level is a multiple of the minimum, zero meaning off.
module rac_tone_decode
    import rac_pkg::*;
(
    // Raw fields
    input  wire logic [1:0] freq_code,
    input  wire logic [2:0] level_code,
    // Decoded tone settings
    output rac_tone_div_t   tone_div,
    output logic [2:0]      tone_mult
);

    // Divider select
    always_comb begin
        case (freq_code)
            2'h1:    tone_div = RAC_DIV_4;
            2'h2:    tone_div = RAC_DIV_8;
            2'h3:    tone_div = RAC_DIV_16;
            default: tone_div = RAC_DIV_OFF;
        endcase
    end

    // Level as multiple of the minimum step
    always_comb begin
        case (level_code)
            3'h1, 3'h2: tone_mult = 3'h1;
            3'h3, 3'h4: tone_mult = 3'h2;
            3'h5, 3'h6: tone_mult = 3'h3;
            3'h7:       tone_mult = 3'h4;
            default:    tone_mult = 3'h0;
        endcase
    end

endmodule

// [rtl/rac_regs.sv]
// Purpose: Receive auxiliary control registers on an Avalon-MM slave.
// Assumes: receive_state and if_bw_khz come from logic on clk_sys;
//          chip_select_pin is asynchronous and is synchronised here.
// Notes:   Every access answers with one wait cycle; unmapped reads
//          return zero and unmapped writes are dropped.
//          Only byte lane 0 carries register data; a write with lane 0
//          disabled is acknowledged but changes nothing.
//          Entry into the receive state reloads the pull-in limit and
//          wins over a host write to that register in the same cycle.
`include "rac_defines.svh"

module rac_regs
    import rac_pkg::*;
#(
    parameter int IF_BW_W = 9
)
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,

    // Avalon-MM slave
    input  wire logic [`RAC_ADDR_W-1:0] address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [3:0]             byteenable,
    input  wire logic [`RAC_DATA_W-1:0] writedata,
    output logic      [`RAC_DATA_W-1:0] readdata,
    output logic                        waitrequest,

    // Command processor side
    input  wire logic                   receive_state,
    input  wire logic [IF_BW_W-1:0]     if_bw_khz,

    // Serial chip select pin
    input  wire logic                   chip_select_pin,

    // Frequency correction
    output logic      [7:0]             afc_pull_in_limit,

    // Image-reject calibration source
    output logic                        ir_cal_result_override,
    output rac_tone_div_t               cal_tone_div,
    output logic      [2:0]             cal_tone_mult,

    // Shutdown
    output logic                        shutdown_request,
    output logic                        shutdown_start,

    // Receive front-end enables
    output logic                        converter_on,
    output logic                        signal_strength_on,
    output logic                        if_filter_on,
    output logic                        mixer_on,
    output logic                        low_noise_amp_on
);

    // Register storage
    logic [7:0]       afc_limit_q;
    logic [5:0]       ir_cal_q;
    logic             shdn_req_q;
    logic [4:0]       rx_pwr_q;

    // Bus handshake
    rac_bus_state_t   bus_state_q;
    logic             wait_q;
    logic [31:0]      rdata_q;

    // Receive state edge detect
    logic             rx_state_q;
    logic             rx_entry;
    logic [7:0]       half_bw;

    // Synchronised chip select
    logic             cs_level;

    // Registered outputs
    logic             ovr_q;
    rac_tone_div_t    div_q;
    logic [2:0]       mult_q;
    logic             shdn_start_q;
    logic             conv_q;
    logic             sig_q;
    logic             ifilt_q;
    logic             mix_q;
    logic             lna_q;

    // Decoder results
    rac_tone_div_t    div_d;
    logic [2:0]       mult_d;

    // Read mux and write strobes
    logic [31:0]      rdata_d;
    logic             wr_take;
    logic             wr_lane0;

    // Per-register write strobes
    logic             wr_afc;
    logic             wr_ir;
    logic             wr_shdn;
    logic             wr_rxp;

    // Image-reject setup fields
    logic             ir_ovr_bit;
    logic [1:0]       ir_freq_code;
    logic [2:0]       ir_level_code;

    // Register hit for a given index
    function automatic logic reg_hit(
        input logic [`RAC_ADDR_W-1:0] addr,
        input logic [11:0]            idx
    );
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // Chip select synchroniser
    rac_sync u_cs_sync (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .pin_in    (chip_select_pin),
        .level_out (cs_level)
    );

    // Test tone decoder
    rac_tone_decode u_tone (
        .freq_code  (ir_freq_code),
        .level_code (ir_level_code),
        .tone_div   (div_d),
        .tone_mult  (mult_d)
    );

    // Write happens at the edge where the master sees waitrequest low
    assign wr_take  = write && !wait_q;
    assign wr_lane0 = wr_take && byteenable[0];

    // Write decode; one strobe per register, all low without a lane-0 write
    always_comb begin
        wr_afc  = 1'b0;
        wr_ir   = 1'b0;
        wr_shdn = 1'b0;
        wr_rxp  = 1'b0;
        if (wr_lane0) begin
            wr_afc  = reg_hit(address, `RAC_IDX_AFC_LIMIT);
            wr_ir   = reg_hit(address, `RAC_IDX_IR_CAL);
            wr_shdn = reg_hit(address, `RAC_IDX_SHUTDOWN);
            wr_rxp  = reg_hit(address, `RAC_IDX_RX_POWER);
        end
    end

    // Field split of the image-reject setup
    assign ir_ovr_bit    = ir_cal_q[`RAC_IR_OVR_BIT];
    assign ir_freq_code  = ir_cal_q[`RAC_IR_FREQ_HI:`RAC_IR_FREQ_LO];
    assign ir_level_code = ir_cal_q[`RAC_IR_LVL_HI:`RAC_IR_LVL_LO];

    // Bus handshake: one wait cycle, then one cycle with waitrequest low
    // The ack cycle always falls back to idle, so a held request is
    // never taken twice and back-to-back accesses need two cycles each
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_state_q <= RAC_IDLE;
            wait_q      <= 1'b1;
        end else begin
            case (bus_state_q)
                RAC_IDLE: begin
                    if (read || write) begin
                        bus_state_q <= RAC_ACK;
                        wait_q      <= 1'b0;
                    end
                end
                RAC_ACK: begin
                    bus_state_q <= RAC_IDLE;
                    wait_q      <= 1'b1;
                end
                default: begin
                    bus_state_q <= RAC_IDLE;
                    wait_q      <= 1'b1;
                end
            endcase
        end
    end

    // Read mux; reserved and unmapped bits read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_hit(address, `RAC_IDX_AFC_LIMIT)) begin
            rdata_d[7:0] = afc_limit_q;
        end else if (reg_hit(address, `RAC_IDX_IR_CAL)) begin
            rdata_d[5:0] = ir_cal_q;
        end else if (reg_hit(address, `RAC_IDX_SHUTDOWN)) begin
            rdata_d[`RAC_SHDN_BIT] = shdn_req_q;
        end else if (reg_hit(address, `RAC_IDX_RX_POWER)) begin
            rdata_d[4:0] = rx_pwr_q;
        end
    end

    // Capture read data so it stands while waitrequest is low
    // Latched in the wait cycle, so a register change at the ack edge
    // cannot tear the word the master takes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_state_q == RAC_IDLE && read) begin
            rdata_q <= rdata_d;
        end
    end

    // Receive state entry edge
    // Idle level of receive_state is low, so reset gives no false entry
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_state_q <= 1'b0;
        end else begin
            rx_state_q <= receive_state;
        end
    end

    assign rx_entry = receive_state && !rx_state_q;
    assign half_bw  = 8'(if_bw_khz >> 1);

    // Pull-in limit; automatic load beats a host write in the same cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            afc_limit_q <= `RAC_RST_AFC_LIMIT;
        end else if (rx_entry) begin
            afc_limit_q <= half_bw;
        end else if (wr_afc) begin
            afc_limit_q <= writedata[7:0];
        end
    end

    // Image-reject setup; reserved bits 7:6 are not stored
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ir_cal_q <= `RAC_RST_IR_CAL;
        end else if (wr_ir) begin
            ir_cal_q <= writedata[5:0];
        end
    end

    // Shutdown request flag
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shdn_req_q <= `RAC_RST_SHUTDOWN;
        end else if (wr_shdn) begin
            shdn_req_q <= writedata[`RAC_SHDN_BIT];
        end
    end

    // Receive front-end enables
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_pwr_q <= `RAC_RST_RX_POWER;
        end else if (wr_rxp) begin
            rx_pwr_q <= writedata[4:0];
        end
    end

    // Calibration source outputs, registered
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ovr_q  <= 1'b0;
            div_q  <= RAC_DIV_OFF;
            mult_q <= 3'h0;
        end else begin
            ovr_q  <= ir_ovr_bit;
            div_q  <= div_d;
            mult_q <= mult_d;
        end
    end

    // Shutdown starts only while chip select is high
    // Uses the synchronised select; the raw pin is never read here
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shdn_start_q <= 1'b0;
        end else begin
            shdn_start_q <= shdn_req_q && cs_level;
        end
    end

    // Front-end enable outputs, registered
    // One extra flop keeps every top-level output straight off a register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            conv_q  <= 1'b0;
            sig_q   <= 1'b0;
            ifilt_q <= 1'b0;
            mix_q   <= 1'b0;
            lna_q   <= 1'b0;
        end else begin
            conv_q  <= rx_pwr_q[`RAC_RX_CONV_BIT];
            sig_q   <= rx_pwr_q[`RAC_RX_SIGSTR_BIT];
            ifilt_q <= rx_pwr_q[`RAC_RX_IFFILT_BIT];
            mix_q   <= rx_pwr_q[`RAC_RX_MIXER_BIT];
            lna_q   <= rx_pwr_q[`RAC_RX_LNA_BIT];
        end
    end

    // Output drive
    assign readdata               = rdata_q;
    assign waitrequest            = wait_q;
    assign afc_pull_in_limit      = afc_limit_q;
    assign ir_cal_result_override = ovr_q;
    assign cal_tone_div           = div_q;
    assign cal_tone_mult          = mult_q;
    assign shutdown_request       = shdn_req_q;
    assign shutdown_start         = shdn_start_q;
    assign converter_on           = conv_q;
    assign signal_strength_on     = sig_q;
    assign if_filter_on           = ifilt_q;
    assign mixer_on               = mix_q;
    assign low_noise_amp_on       = lna_q;

endmodule

// [verif/rac_regs_assertions.sv]
// Purpose: Port level checks of the receive auxiliary control slice.
// Assumes: One clock domain, rstn asynchronous and active low.
// Notes:   Bound into every rac_regs instance.
`include "rac_defines.svh"
module rac_regs_assertions
    import rac_pkg::*;
#(parameter int IF_BW_W = 9)
(
    // Clock, reset and bus
    input wire logic                clk_sys,
    input wire logic                rstn,
    input wire logic [13:0]         address,
    input wire logic                read,
    input wire logic                write,
    input wire logic [3:0]          byteenable,
    input wire logic [31:0]         writedata,
    input wire logic [31:0]         readdata,
    input wire logic                waitrequest,
    // Sources and results
    input wire logic                receive_state,
    input wire logic [IF_BW_W-1:0]  if_bw_khz,
    input wire logic                chip_select_pin,
    input wire logic [7:0]          afc_pull_in_limit,
    input wire logic                ir_cal_result_override,
    input wire rac_tone_div_t       cal_tone_div,
    input wire logic [2:0]          cal_tone_mult,
    input wire logic                shutdown_request,
    input wire logic                shutdown_start,
    input wire logic                converter_on,
    input wire logic                signal_strength_on,
    input wire logic                if_filter_on,
    input wire logic                mixer_on,
    input wire logic                low_noise_amp_on
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wa;
    // Write accepted at this edge
    assign wa = write && !waitrequest && byteenable[0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wait_once_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    afc_read_a: assert property (
        read && !waitrequest && address == 14'hC54
        |-> readdata == {24'h0, afc_pull_in_limit})
        else $error("bad limit read");
    afc_write_a: assert property (wa && address == 14'hC54
        && !$rose(receive_state)
        |=> afc_pull_in_limit == $past(writedata[7:0]))
        else $error("limit write lost");
    auto_load_a: assert property ($rose(receive_state)
        |=> afc_pull_in_limit == 8'($past(if_bw_khz) >> 1))
        else $error("limit not reloaded on receive entry");
    ir_field_a: assert property (wa && address == 14'hC64 |-> ##2
        ir_cal_result_override == $past(writedata[5], 2)
        && cal_tone_div == {1'b0, $past(writedata[4:3], 2)})
        else $error("tone divider or override wrong");
    tone_level_a: assert property (wa && address == 14'hC64 |-> ##2
        cal_tone_mult == 3'(({1'b0, $past(writedata[2:0], 2)} + 4'h1) >> 1))
        else $error("tone level wrong");
    rx_enable_a: assert property (wa && address == 14'hC90 |-> ##2
        {converter_on, signal_strength_on, if_filter_on, mixer_on,
        low_noise_amp_on} == $past(writedata[4:0], 2))
        else $error("receive enables wrong");
    shdn_req_a: assert property (wa && address == 14'hC88
        |=> shutdown_request == $past(writedata[0])) else $error("bad request");
    shdn_cs_a: assert property (
        (!chip_select_pin)[*4] |-> !shutdown_start)
        else $error("shutdown started without chip select");
    // Main scenarios
    cover property ($rose(receive_state));
    cover property (shutdown_start);
    cover property (read && !waitrequest && address == 14'hC88);
endmodule
bind rac_regs rac_regs_assertions #(.IF_BW_W(IF_BW_W))
    u_rac_regs_assertions (.*);

// [verif/rac_host_model.sv]
// Purpose: Host side model issuing Avalon-MM accesses and chip select.
// Assumes: Requests change only just after a rising clock edge.
// Notes:   Holds each request until waitrequest is seen low.
module rac_host_model
(
    // Clock and answer
    input wire logic   clk_sys,
    input wire logic   [31:0] readdata,
    input wire logic   waitrequest,
    // Requests
    output logic       [13:0] address,
    output logic       read,
    output logic       write,
    output logic       [3:0] byteenable,
    output logic       [31:0] writedata,
    output logic       chip_select_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial begin
        address = 14'h0000;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'h0;
        writedata = 32'h0;
        chip_select_pin = 1'b0;
    end
    // One write, held until accepted
    task automatic wr(input logic [13:0] a, input logic [7:0] d,
                      input logic [3:0] be);
        @(posedge clk_sys);
        address <= a;
        writedata <= {24'h000000, d}; // Reserved bits written as zero
        byteenable <= be;
        write <= 1'b1;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    // One read, data taken at the accepting edge
    task automatic rd(input logic [13:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        address <= a;
        read <= 1'b1;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask
    // Chip select level chosen by the host
    task automatic cs(input logic v);
        @(posedge clk_sys);
        chip_select_pin <= v; // Host owns the select level
    endtask
endmodule

// [verif/rac_regs_tb.sv]
// Purpose: Self-checking bench of the receive auxiliary control slice.
// Assumes: Host model drives the bus; bench drives command inputs.
// Notes:   Outputs are sampled on the falling edge.
module rac_regs_tb
    import rac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, rstn = 1'b0, receive_state = 1'b0;
    logic [8:0] if_bw_khz = 9'h000;
    logic [13:0] address;
    logic read, write, waitrequest, chip_select_pin, ir_cal_result_override;
    logic shutdown_request, shutdown_start, converter_on, signal_strength_on;
    logic if_filter_on, mixer_on, low_noise_amp_on;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, rv;
    logic [7:0] afc_pull_in_limit;
    logic [2:0] cal_tone_mult;
    rac_tone_div_t cal_tone_div;
    logic [4:0] rx_on;
    int err_total = 0, total_checks = 0;
    logic [7:0] rxv [3] = '{8'h15, 8'h0A, 8'h1F};
    always #50 clk_sys = ~clk_sys;
    // Front-end enables as one word, converter in the top bit
    assign rx_on = {converter_on, signal_strength_on, if_filter_on, mixer_on,
        low_noise_amp_on};
    rac_regs u_rac_regs (.clk_sys(clk_sys), .rstn(rstn), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .receive_state(receive_state), .if_bw_khz(if_bw_khz),
        .chip_select_pin(chip_select_pin),
        .afc_pull_in_limit(afc_pull_in_limit),
        .ir_cal_result_override(ir_cal_result_override),
        .cal_tone_div(cal_tone_div), .cal_tone_mult(cal_tone_mult),
        .shutdown_request(shutdown_request), .shutdown_start(shutdown_start),
        .converter_on(converter_on), .signal_strength_on(signal_strength_on),
        .if_filter_on(if_filter_on), .mixer_on(mixer_on),
        .low_noise_amp_on(low_noise_amp_on));
    rac_host_model u_rac_host_model (.clk_sys(clk_sys), .readdata(readdata),
        .waitrequest(waitrequest), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .chip_select_pin(chip_select_pin));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Let derived outputs land
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // Enter the receive state with a given bandwidth
    task automatic enter_rx(input logic [8:0] bw);
        @(posedge clk_sys);
        receive_state <= 1'b0;
        if_bw_khz <= bw;
        @(posedge clk_sys);
        receive_state <= 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // Hang guard
    initial begin
        #2000000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(negedge clk_sys);
        chk(32'(afc_pull_in_limit), 32'h32);
        chk(32'(rx_on), 32'h0);
        chk(32'(waitrequest), 32'h1);
        chk(readdata, 32'h0);
        chk(32'({ir_cal_result_override, cal_tone_div}), 32'h0);
        chk(32'(cal_tone_mult), 32'h0);
        chk(32'({shutdown_request, shutdown_start}), 32'h0);
        u_rac_host_model.rd(14'hC54, rv);
        chk(rv, 32'h32);
        u_rac_host_model.rd(14'hC64, rv);
        chk(rv, 32'h0);
        u_rac_host_model.rd(14'hC88, rv);
        chk(rv, 32'h0);
        u_rac_host_model.rd(14'hC90, rv);
        chk(rv, 32'h0);
        // Write, lane-off write and unmapped access
        u_rac_host_model.wr(14'hC54, 8'hA5, 4'h1);
        u_rac_host_model.wr(14'hC54, 8'h5A, 4'h0);
        u_rac_host_model.rd(14'hC54, rv);
        chk(rv, 32'hA5);
        u_rac_host_model.wr(14'hC60, 8'h5A, 4'h1);
        u_rac_host_model.rd(14'hC60, rv);
        chk(rv, 32'h0);
        // Every tone divider and level code
        for (int k = 0; k < 32; k++) begin
            u_rac_host_model.wr(14'hC64, {2'b00, k[0], k[4:3], k[2:0]}, 4'h1);
            settle();
            chk(32'(ir_cal_result_override), 32'(k[0]));
            chk(32'(cal_tone_div), 32'(k[4:3]));
            chk(32'(cal_tone_mult), 32'((k[2:0] + 1) / 2));
        end
        // Receive enables
        foreach (rxv[i]) begin
            u_rac_host_model.wr(14'hC90, rxv[i], 4'h1);
            settle();
            chk(32'(rx_on), 32'(rxv[i][4:0]));
            u_rac_host_model.rd(14'hC90, rv);
            chk(rv, 32'(rxv[i]));
        end
        // Automatic limit reload, host write in between
        enter_rx(9'd200);
        chk(32'(afc_pull_in_limit), 32'd100);
        u_rac_host_model.wr(14'hC54, 8'h11, 4'h1);
        u_rac_host_model.rd(14'hC54, rv);
        chk(rv, 32'h11);
        enter_rx(9'd301);
        chk(32'(afc_pull_in_limit), 32'd150);
        // Shutdown needs chip select high
        u_rac_host_model.cs(1'b0);
        u_rac_host_model.wr(14'hC88, 8'h01, 4'h1);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'({shutdown_request, shutdown_start}), 32'h2);
        u_rac_host_model.cs(1'b1);
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'(shutdown_start), 32'h1);
        u_rac_host_model.rd(14'hC88, rv);
        chk(rv, 32'h1);
        u_rac_host_model.wr(14'hC88, 8'h00, 4'h1);
        settle();
        chk(32'(shutdown_start), 32'h0);
        conclude();
    end
endmodule
